/* File: shared/i2cm_regs.vh */
// Register map, field positions and reset values of the I2C master port
`ifndef I2CM_REGS_VH
`define I2CM_REGS_VH
`define I2CM_A_BUF 4'h0
`define I2CM_A_STAT 4'h1
`define I2CM_A_CTL1 4'h2
`define I2CM_A_CTL2 4'h3
`define I2CM_A_RATE 4'h4
`define I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_1 4'h5
`define I2CM_A_PERIPHERAL_INTERRUPT_ENABLES_1 4'h6
`define I2CM_A_PERIPHERAL_INTERRUPT_PRIORITY_1 4'h7
`define I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_2 4'h8
`define I2CM_A_PERIPHERAL_INTERRUPT_ENABLES_2 4'h9
`define I2CM_A_PERIPHERAL_INTERRUPT_PRIORITY_2 4'hA
`define I2CM_RST_PERIPHERAL_INTERRUPT_FLAGS_1 8'h00
`define I2CM_RST_PERIPHERAL_INTERRUPT_ENABLES_1 8'h00
`define I2CM_RST_PERIPHERAL_INTERRUPT_PRIORITY_1 8'h7F
`define I2CM_RST_PERIPHERAL_INTERRUPT_FLAGS_2 8'h00
`define I2CM_RST_PERIPHERAL_INTERRUPT_ENABLES_2 8'h00
`define I2CM_RST_PERIPHERAL_INTERRUPT_PRIORITY_2 8'h00
`define I2CM_RST_RATE 8'h00
`define I2CM_PERIPHERAL_INTERRUPT_FLAGS_2_MASK 8'h5F
`define I2CM_ST_BF 0
`define I2CM_ST_S 3
`define I2CM_ST_P 4
`define I2CM_C1_WRITE_COLLISION_FLAG 7
`define I2CM_C1_OV 6
`define I2CM_C1_EN 5
`define I2CM_C2_ACK_STATUS_FLAG 6
`define I2CM_C2_ACKDT 5
`define I2CM_C2_ACK_SEQUENCE_ENABLE 4
`define I2CM_C2_RECEIVE_ENABLE_BIT 3
`define I2CM_C2_PEN 2
`define I2CM_C2_RSEN 1
`define I2CM_C2_SEN 0
`define I2CM_IRQ_BIT 3
`define I2CM_BCL_BIT 3
`define I2CM_BRG_W 7
`define I2CM_BYTE_LAST 4'h7
`define I2CM_ACK_SLOT 4'h8
`endif

/* File: hw/i2cm_core.v */
// I2C master port: buffer, flags, rate generator, reception and arbitration
// Functional notes
// RQ1: Transmit sets buffer-full on buffer write, clears after eight bits shifted out.
// RQ2: Buffer write while shifting sets write-collision and is discarded.
// RQ3: Write-collision is cleared only by software writing the flag.
// RQ4: Acknowledge status clears on slave ACK low, sets on ACK high.
// RQ5: Receive-enable starts reception; ignored unless the port is idle.
// RQ6: Each rate rollover in reception toggles clock; data shifts in only on every second rollover, as the clock is pulled low.
// RQ7: After eighth receive clock: clear enable, load buffer, set flags, hold clock low.
// RQ8: Receive sets buffer-full on buffer load; buffer read clears it.
// RQ9: Software sets acknowledge-sequence-enable to acknowledge a received byte.
// RQ10: Overflow flag sets when a byte completes while buffer-full is set.
// RQ11: Reception continues in sleep; wake on completed byte if interrupt enabled.
// RQ12: Reset disables the port and aborts any transfer.
// RQ13: Start and stop detected bits clear on reset or when disabled.
// RQ14: Software claims the bus only when stop seen or both bits clear.
// RQ15: Stop detected on a busy bus raises the port interrupt flag.
// RQ16: Released data line sampled low while clock high is a collision.
// RQ17: Arbitration checked in address, data, start, repeated start, acknowledge.
// RQ18: Collision in transmit halts, clears buffer-full, releases lines.
// RQ19: Collision in a sequence aborts it and clears its enable bit.
// RQ20: After a collision, a detected stop sets the port interrupt flag.
// RQ21: After a collision, a buffer write restarts from the first data bit.
// RQ22: Software restarts with a new start once the bus is free.
// RQ23: Rate generator reloads from low seven reload bits and counts down.
// RQ24: After ninth transmit clock set interrupt flag, suspend with clock low.
// RQ25: Software clears collision and interrupt flags; hardware only sets them.
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "i2cm_regs.vh"
module i2cm_core (
  input wire core_clk, // 100 MHz clock
  input wire reset, // Synchronous, active high
  input wire [3:0] avs_address, // Word address
  input wire avs_read, // Read request
  input wire avs_write, // Write request
  input wire [31:0] avs_writedata, // Write data
  output wire [31:0] avs_readdata, // Read data
  output wire avs_waitrequest, // Stall
  input wire scl_in, // Clock line level
  output wire scl_out, // Clock drive value, always 0
  output wire scl_oe_n, // Low pulls clock line low
  input wire sda_in, // Data line level
  output wire sda_out, // Data drive value, always 0
  output wire sda_oe_n, // Low pulls data line low
  input wire cpu_sleep, // Processor is asleep
  output wire wake_req // Wake the processor
);
  // Engine states; only idle accepts a new command
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_RSTART = 3'h2;
  localparam ST_STOP = 3'h3;
  localparam ST_TX = 3'h4;
  localparam ST_RX = 3'h5;
  localparam ST_ACK = 3'h6;

  // Bus handshake, register file and engine state
  reg ack_q;
  reg [7:0] rdata_q;
  reg [7:0] buf_q, shreg_q, rate_q, ctl2_q, peripheral_interrupt_flags_1_q, peripheral_interrupt_enables_1_q, peripheral_interrupt_priority_1_q, peripheral_interrupt_flags_2_q, peripheral_interrupt_enables_2_q, peripheral_interrupt_priority_2_q;
  reg bf_q, write_collision_flag_q, ov_q, en_q, s_q, p_q;
  reg [2:0] state_q;
  reg [1:0] phase_q;
  reg [3:0] bit_q;
  reg [`I2CM_BRG_W-1:0] brg_q;
  reg scl_low_q, sda_low_q, scl_prev_q, sda_prev_q;

  wire req = avs_read | avs_write;
  wire wr = ack_q & avs_write;
  wire rd = ack_q & avs_read;
  wire idle = (state_q == ST_IDLE);
  // One rollover per half bit period; no rollover while idle
  wire tick = ~idle & (brg_q == {`I2CM_BRG_W{1'b0}});
  // Line history resets high, the idle level, so no false edge follows reset
  wire start_seen = scl_in & scl_prev_q & sda_prev_q & ~sda_in;
  wire stop_seen = scl_in & scl_prev_q & ~sda_prev_q & sda_in;
  // Released data line read low with clock high: another master owns the bus
  wire lost = scl_in & ~sda_low_q & ~sda_in; // RQ16

  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata = {24'h000000, rdata_q};
  // Pins only pull low; a released line rises through its pull-up
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = ~scl_low_q;
  assign sda_oe_n = ~sda_low_q;
  assign wake_req = cpu_sleep & peripheral_interrupt_flags_1_q[`I2CM_IRQ_BIT] & peripheral_interrupt_enables_1_q[`I2CM_IRQ_BIT]; // RQ11

  // One wait state; read data is registered in the stalled cycle
  always @(posedge core_clk) begin
    if (reset) begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read & ~ack_q) begin
        if (avs_address == `I2CM_A_BUF) rdata_q <= buf_q;
        else if (avs_address == `I2CM_A_STAT)
          rdata_q <= {3'b000, p_q, s_q, 2'b00, bf_q};
        else if (avs_address == `I2CM_A_CTL1) rdata_q <= {write_collision_flag_q, ov_q, en_q, 5'h00};
        else if (avs_address == `I2CM_A_CTL2) rdata_q <= ctl2_q;
        else if (avs_address == `I2CM_A_RATE) rdata_q <= rate_q;
        else if (avs_address == `I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_1) rdata_q <= peripheral_interrupt_flags_1_q;
        else if (avs_address == `I2CM_A_PERIPHERAL_INTERRUPT_ENABLES_1) rdata_q <= peripheral_interrupt_enables_1_q;
        else if (avs_address == `I2CM_A_PERIPHERAL_INTERRUPT_PRIORITY_1) rdata_q <= peripheral_interrupt_priority_1_q;
        else if (avs_address == `I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_2) rdata_q <= peripheral_interrupt_flags_2_q;
        else if (avs_address == `I2CM_A_PERIPHERAL_INTERRUPT_ENABLES_2) rdata_q <= peripheral_interrupt_enables_2_q;
        else if (avs_address == `I2CM_A_PERIPHERAL_INTERRUPT_PRIORITY_2) rdata_q <= peripheral_interrupt_priority_2_q;
        // Unmapped words read as zero
        else rdata_q <= 8'h00;
      end
    end
  end

  // Plain storage registers and bus line history
  always @(posedge core_clk) begin
    if (reset) begin
      rate_q <= `I2CM_RST_RATE;
      peripheral_interrupt_enables_1_q <= `I2CM_RST_PERIPHERAL_INTERRUPT_ENABLES_1;
      peripheral_interrupt_priority_1_q <= `I2CM_RST_PERIPHERAL_INTERRUPT_PRIORITY_1;
      peripheral_interrupt_enables_2_q <= `I2CM_RST_PERIPHERAL_INTERRUPT_ENABLES_2;
      peripheral_interrupt_priority_2_q <= `I2CM_RST_PERIPHERAL_INTERRUPT_PRIORITY_2;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_in;
      sda_prev_q <= sda_in;
      if (wr && avs_address == `I2CM_A_RATE) rate_q <= avs_writedata[7:0];
      if (wr && avs_address == `I2CM_A_PERIPHERAL_INTERRUPT_ENABLES_1) peripheral_interrupt_enables_1_q <= avs_writedata[7:0];
      if (wr && avs_address == `I2CM_A_PERIPHERAL_INTERRUPT_PRIORITY_1) peripheral_interrupt_priority_1_q <= avs_writedata[7:0];
      // Unused bits of the second bank always read as zero
      if (wr && avs_address == `I2CM_A_PERIPHERAL_INTERRUPT_ENABLES_2) peripheral_interrupt_enables_2_q <= avs_writedata[7:0] & `I2CM_PERIPHERAL_INTERRUPT_FLAGS_2_MASK;
      if (wr && avs_address == `I2CM_A_PERIPHERAL_INTERRUPT_PRIORITY_2) peripheral_interrupt_priority_2_q <= avs_writedata[7:0] & `I2CM_PERIPHERAL_INTERRUPT_FLAGS_2_MASK;
    end
  end

  // Bus-free tracking from start and stop conditions on the lines
  always @(posedge core_clk) begin
    if (reset || !en_q) begin // RQ13
      s_q <= 1'b0;
      p_q <= 1'b0;
    end else if (start_seen) begin
      s_q <= 1'b1;
      p_q <= 1'b0;
    end else if (stop_seen) begin
      s_q <= 1'b0;
      p_q <= 1'b1;
    end
  end

  // Rate generator: half bit period, suspended while idle
  always @(posedge core_clk) begin
    if (reset || idle || tick) brg_q <= rate_q[`I2CM_BRG_W-1:0]; // RQ23
    else brg_q <= brg_q - {{(`I2CM_BRG_W-1){1'b0}}, 1'b1};
  end

  // Engine, flags and software-visible control
  always @(posedge core_clk) begin
    if (reset) begin // RQ12
      state_q <= ST_IDLE;
      phase_q <= 2'b00;
      bit_q <= 4'h0;
      buf_q <= 8'h00;
      shreg_q <= 8'h00;
      ctl2_q <= 8'h00;
      peripheral_interrupt_flags_1_q <= `I2CM_RST_PERIPHERAL_INTERRUPT_FLAGS_1;
      peripheral_interrupt_flags_2_q <= `I2CM_RST_PERIPHERAL_INTERRUPT_FLAGS_2;
      bf_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      ov_q <= 1'b0;
      en_q <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else begin
      // Software writes first; hardware sets below override, so a set wins
      if (wr && avs_address == `I2CM_A_CTL1) begin
        write_collision_flag_q <= avs_writedata[`I2CM_C1_WRITE_COLLISION_FLAG]; // RQ3
        ov_q <= avs_writedata[`I2CM_C1_OV];
        en_q <= avs_writedata[`I2CM_C1_EN];
      end
      if (wr && avs_address == `I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_1) peripheral_interrupt_flags_1_q <= avs_writedata[7:0]; // RQ25
      if (wr && avs_address == `I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_2) peripheral_interrupt_flags_2_q <= avs_writedata[7:0] & `I2CM_PERIPHERAL_INTERRUPT_FLAGS_2_MASK;
      if (rd && avs_address == `I2CM_A_BUF) bf_q <= 1'b0; // RQ8
      if (wr && avs_address == `I2CM_A_CTL2) begin
        ctl2_q[`I2CM_C2_ACKDT] <= avs_writedata[`I2CM_C2_ACKDT];
        // No queueing: sequence enables are taken only while idle
        if (idle && en_q) begin // RQ5
          ctl2_q[4:0] <= avs_writedata[4:0];
          if (avs_writedata[`I2CM_C2_SEN]) begin
            state_q <= ST_START;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
          end else if (avs_writedata[`I2CM_C2_RSEN]) begin
            state_q <= ST_RSTART;
            sda_low_q <= 1'b0;
          end else if (avs_writedata[`I2CM_C2_PEN]) begin
            state_q <= ST_STOP;
            sda_low_q <= 1'b1;
          end else if (avs_writedata[`I2CM_C2_RECEIVE_ENABLE_BIT]) begin // RQ5
            state_q <= ST_RX;
            sda_low_q <= 1'b0;
          end else if (avs_writedata[`I2CM_C2_ACK_SEQUENCE_ENABLE]) begin
            state_q <= ST_ACK;
            sda_low_q <= ~avs_writedata[`I2CM_C2_ACKDT];
          end
          phase_q <= 2'b00;
          bit_q <= 4'h0;
        end
      end
      if (wr && avs_address == `I2CM_A_BUF) begin
        if (!idle) write_collision_flag_q <= 1'b1; // RQ2
        else if (en_q) begin
          // Always begins at the first data bit, also after a collision
          buf_q <= avs_writedata[7:0];
          shreg_q <= avs_writedata[7:0]; // RQ21
          bf_q <= 1'b1; // RQ1
          state_q <= ST_TX;
          phase_q <= 2'b00;
          bit_q <= 4'h0;
          scl_low_q <= 1'b1;
          sda_low_q <= ~avs_writedata[7];
        end
      end
      // Stop on the bus, also while recovering from a lost arbitration
      if (en_q && stop_seen) peripheral_interrupt_flags_1_q[`I2CM_IRQ_BIT] <= 1'b1; // RQ15 RQ20

      if (tick) begin
        case (state_q)
          ST_START: begin
            // Either line already low: another master holds the bus
            if (phase_q == 2'b00) begin
              if (!scl_in || !sda_in) begin // RQ17
                ctl2_q[`I2CM_C2_SEN] <= 1'b0; // RQ19
                peripheral_interrupt_flags_2_q[`I2CM_BCL_BIT] <= 1'b1;
                state_q <= ST_IDLE;
              end else begin
                sda_low_q <= 1'b1;
                phase_q <= 2'b01;
              end
            end else begin
              ctl2_q[`I2CM_C2_SEN] <= 1'b0;
              peripheral_interrupt_flags_1_q[`I2CM_IRQ_BIT] <= 1'b1;
              state_q <= ST_IDLE;
            end
          end
          ST_RSTART: begin
            // Clock floats up first, then data falls with the clock high
            if (phase_q == 2'b00) begin
              scl_low_q <= 1'b0;
              phase_q <= 2'b01;
            end else if (phase_q == 2'b01) begin
              if (lost) begin // RQ17
                ctl2_q[`I2CM_C2_RSEN] <= 1'b0; // RQ19
                peripheral_interrupt_flags_2_q[`I2CM_BCL_BIT] <= 1'b1;
                state_q <= ST_IDLE;
              end else begin
                sda_low_q <= 1'b1;
                phase_q <= 2'b10;
              end
            end else begin
              ctl2_q[`I2CM_C2_RSEN] <= 1'b0;
              peripheral_interrupt_flags_1_q[`I2CM_IRQ_BIT] <= 1'b1;
              state_q <= ST_IDLE;
            end
          end
          ST_STOP: begin
            // Data rising while the clock is high forms the stop condition
            if (phase_q == 2'b00) begin
              scl_low_q <= 1'b0;
              phase_q <= 2'b01;
            end else if (phase_q == 2'b01) begin
              sda_low_q <= 1'b0;
              phase_q <= 2'b10;
            end else begin
              if (lost) begin
                ctl2_q[`I2CM_C2_PEN] <= 1'b0; // RQ19
                peripheral_interrupt_flags_2_q[`I2CM_BCL_BIT] <= 1'b1;
                state_q <= ST_IDLE;
              end else begin
                ctl2_q[`I2CM_C2_PEN] <= 1'b0;
                peripheral_interrupt_flags_1_q[`I2CM_IRQ_BIT] <= 1'b1;
                state_q <= ST_IDLE;
              end
            end
          end
          ST_TX: begin
            if (phase_q == 2'b00) begin
              scl_low_q <= 1'b0;
              phase_q <= 2'b01;
            end else if (bit_q == `I2CM_ACK_SLOT) begin
              // Ninth clock: the slave's answer is taken just before the clock falls
              ctl2_q[`I2CM_C2_ACK_STATUS_FLAG] <= sda_in; // RQ4
              peripheral_interrupt_flags_1_q[`I2CM_IRQ_BIT] <= 1'b1; // RQ24
              scl_low_q <= 1'b1;
              state_q <= ST_IDLE;
            end else if (lost) begin // RQ17
              bf_q <= 1'b0; // RQ18
              peripheral_interrupt_flags_2_q[`I2CM_BCL_BIT] <= 1'b1;
              state_q <= ST_IDLE;
            end else begin
              scl_low_q <= 1'b1;
              shreg_q <= {shreg_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
              phase_q <= 2'b00;
              if (bit_q == `I2CM_BYTE_LAST) begin
                bf_q <= 1'b0; // RQ1
                sda_low_q <= 1'b0;
              end else begin
                sda_low_q <= ~shreg_q[6];
              end
            end
          end
          ST_RX: begin
            // Data is taken at the end of the high phase, when it has settled longest
            if (phase_q == 2'b00) begin
              scl_low_q <= 1'b0; // RQ6
              phase_q <= 2'b01;
            end else begin
              scl_low_q <= 1'b1; // RQ6
              shreg_q <= {shreg_q[6:0], sda_in};
              bit_q <= bit_q + 4'h1;
              phase_q <= 2'b00;
              if (bit_q == `I2CM_BYTE_LAST) begin
                ctl2_q[`I2CM_C2_RECEIVE_ENABLE_BIT] <= 1'b0; // RQ7
                peripheral_interrupt_flags_1_q[`I2CM_IRQ_BIT] <= 1'b1;
                state_q <= ST_IDLE;
                // An unread byte is kept; the new one is dropped
                if (bf_q) ov_q <= 1'b1; // RQ10
                else begin
                  buf_q <= {shreg_q[6:0], sda_in};
                  bf_q <= 1'b1; // RQ8
                end
              end
            end
          end
          ST_ACK: begin
            // A floating acknowledge bit read low means another master won
            if (phase_q == 2'b00) begin
              scl_low_q <= 1'b0;
              phase_q <= 2'b01;
            end else begin
              ctl2_q[`I2CM_C2_ACK_SEQUENCE_ENABLE] <= 1'b0;
              state_q <= ST_IDLE;
              if (lost) begin // RQ17
                peripheral_interrupt_flags_2_q[`I2CM_BCL_BIT] <= 1'b1; // RQ19
              end else begin
                scl_low_q <= 1'b1;
                peripheral_interrupt_flags_1_q[`I2CM_IRQ_BIT] <= 1'b1;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase

        // A lost arbitration lets go of both lines
        if (lost && state_q != ST_RX && phase_q != 2'b00 && bit_q != `I2CM_ACK_SLOT) begin
          scl_low_q <= 1'b0; // RQ18 RQ19
          sda_low_q <= 1'b0;
        end
        if (state_q == ST_START && phase_q == 2'b00 && (!scl_in || !sda_in)) begin
          scl_low_q <= 1'b0;
          sda_low_q <= 1'b0;
        end
      end

      // Disabling the port aborts the transfer and frees the bus
      if (!en_q) begin // RQ12
        state_q <= ST_IDLE;
        ctl2_q[4:0] <= 5'h00;
        scl_low_q <= 1'b0;
        sda_low_q <= 1'b0;
      end
    end
  end
endmodule // i2cm_core

/* File: verification/i2cm_monitor.sv */
// Checker on the ports of the I2C master port
`timescale 1ns/100ps
module i2cm_monitor (
  input wire core_clk, // Clock
  input wire reset, // Sync reset
  input wire [3:0] avs_address, // Address
  input wire avs_read, // Read
  input wire avs_write, // Write
  input wire [31:0] avs_readdata, // Read data
  input wire avs_waitrequest, // Stall
  input wire scl_out, // Clock value
  input wire scl_oe_n, // Clock pull
  input wire sda_out, // Data value
  input wire sda_oe_n, // Data pull
  input wire cpu_sleep, // Asleep
  input wire wake_req // Wake
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  wire req = avs_read | avs_write;
  a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("first cycle not stalled");
  a_wait_once: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_read_unmapped: assert property (avs_read && !avs_waitrequest && avs_address > 4'hA
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_flags2_mask: assert property (avs_read && !avs_waitrequest && avs_address >= 4'h8
    && avs_address <= 4'hA |-> (avs_readdata[7:0] & 8'hA0) == 8'h00)
    else $error("unused bits read as one");
  a_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved while idle");
  a_lines_free: assert property ($past(reset) |-> scl_oe_n && sda_oe_n)
    else $error("line pulled after reset");
  a_drive_zero: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("drive value not zero");
  a_wake_gate: assert property (wake_req |-> cpu_sleep)
    else $error("wake while awake");
endmodule // i2cm_monitor
bind i2cm_core i2cm_monitor u_mon (.core_clk(core_clk), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_out(scl_out),
  .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cpu_sleep(cpu_sleep),
  .wake_req(wake_req));

/* File: verification/i2cm_slave_model.sv */
// Behavioural slave and rival master on the bus side
`timescale 1ns/100ps
module i2cm_slave_model (
  input wire core_clk, // Clock
  input wire scl, // Clock line level
  input wire arm, // Restart bit count
  input wire send, // Drive tx_byte
  input wire ack_en, // Acknowledge a byte
  input wire [7:0] tx_byte, // Byte to send
  input wire collide, // Rival pulls data low
  output wire sda_pull_n // Low pulls data line
);
  reg scl_q;
  reg [3:0] cnt_q;
  reg drv_q;
  always @(posedge core_clk) begin
    scl_q <= scl;
    if (arm) begin
      cnt_q <= 4'h0;
      drv_q <= 1'b1;
    end else begin
      if (scl && !scl_q) cnt_q <= cnt_q + 4'h1;
      // Data only moves while the clock is low
      if (!scl && send) drv_q <= (cnt_q < 4'h8) ? tx_byte[~cnt_q[2:0]] : 1'b1;
      else if (!scl) drv_q <= !(ack_en && cnt_q == 4'h8);
    end
  end
  assign sda_pull_n = drv_q & !collide;
endmodule // i2cm_slave_model

/* File: verification/test_i2c_master_flags_and_arbitration.sv */
// Self-checking bench for the I2C master port
`timescale 1ns/100ps
`include "i2cm_regs.vh"
module test_i2c_master_flags_and_arbitration;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic cpu_sleep = 1'b0;
  logic arm = 1'b1;
  logic send = 1'b0;
  logic ack_en = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic collide = 1'b0;
  logic [15:0] cap = 16'h0;
  logic [7:0] rdq, d;
  logic [7:0] b [2];
  int n_fail = 0;
  int n_tests = 0;
  int k, rs;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, scl_out, scl_oe_n, sda_out, sda_oe_n, wake_req, sda_pull_n;
  wire scl_w = scl_oe_n;
  wire sda_w = sda_oe_n & sda_pull_n;
  always #5 core_clk = ~core_clk;
  always @(posedge scl_w) cap <= {cap[14:0], sda_w};
  i2cm_core i_dut (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .cpu_sleep(cpu_sleep), .wake_req(wake_req));
  i2cm_slave_model i_slv (.core_clk(core_clk), .scl(scl_w), .arm(arm), .send(send),
    .ack_en(ack_en), .tx_byte(tx_byte), .collide(collide), .sda_pull_n(sda_pull_n));
  task close_out;
    begin
      if (n_fail == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task acc(input logic wr, input logic [3:0] a, input logic [7:0] v);
    int i;
    begin
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, v};
      avs_write <= wr;
      avs_read <= ~wr;
      i = 0;
      // Waitrequest and read data are taken as they stand at the rising edge
      do begin
        @(posedge core_clk);
        i = i + 1;
      end while (avs_waitrequest !== 1'b0 && i < 50);
      if (avs_waitrequest !== 1'b0) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t bus timeout", $time);
        close_out;
      end
      rdq = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    begin
      acc(1'b0, a, 8'h00);
      chk(rdq & m, e);
    end
  endtask
  // Polls a flag; a flag that never comes ends the run
  task wt(input logic [3:0] a, input int bp);
    int i;
    begin
      i = 0;
      rdq = 8'h00;
      while (rdq[bp] !== 1'b1 && i < 300) begin
        acc(1'b0, a, 8'h00);
        i = i + 1;
      end
      chk({7'h0, rdq[bp]}, 8'h01);
      if (rdq[bp] !== 1'b1) close_out;
    end
  endtask
  task prep(input logic [7:0] v);
    begin
      @(posedge core_clk);
      tx_byte <= v;
      arm <= 1'b1;
      @(posedge core_clk);
      arm <= 1'b0;
    end
  endtask
  initial begin
    rs = $urandom(38);
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    arm <= 1'b0;
    rc(`I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_1, 8'hFF, `I2CM_RST_PERIPHERAL_INTERRUPT_FLAGS_1);
    rc(`I2CM_A_PERIPHERAL_INTERRUPT_ENABLES_1, 8'hFF, `I2CM_RST_PERIPHERAL_INTERRUPT_ENABLES_1);
    rc(`I2CM_A_PERIPHERAL_INTERRUPT_PRIORITY_1, 8'hFF, `I2CM_RST_PERIPHERAL_INTERRUPT_PRIORITY_1);
    rc(`I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_2, 8'hFF, `I2CM_RST_PERIPHERAL_INTERRUPT_FLAGS_2);
    rc(`I2CM_A_PERIPHERAL_INTERRUPT_ENABLES_2, 8'hFF, `I2CM_RST_PERIPHERAL_INTERRUPT_ENABLES_2);
    rc(`I2CM_A_PERIPHERAL_INTERRUPT_PRIORITY_2, 8'hFF, `I2CM_RST_PERIPHERAL_INTERRUPT_PRIORITY_2);
    rc(`I2CM_A_RATE, 8'hFF, `I2CM_RST_RATE);
    acc(1'b1, 4'hB, 8'hFF);
    rc(4'hB, 8'hFF, 8'h00);
    acc(1'b1, `I2CM_A_PERIPHERAL_INTERRUPT_PRIORITY_2, 8'hFF);
    rc(`I2CM_A_PERIPHERAL_INTERRUPT_PRIORITY_2, 8'hFF, `I2CM_PERIPHERAL_INTERRUPT_FLAGS_2_MASK);
    d = 8'($urandom);
    acc(1'b1, `I2CM_A_RATE, {6'h0, d[1:0]} + 8'h01);
    acc(1'b1, `I2CM_A_CTL1, 8'h20);
    for (k = 0; k < 2; k = k + 1) begin
      d = 8'($urandom);
      ack_en <= k[0];
      prep(8'h00);
      acc(1'b1, `I2CM_A_BUF, d);
      rc(`I2CM_A_STAT, 8'h01, 8'h01);
      acc(1'b1, `I2CM_A_BUF, ~d);
      acc(1'b1, `I2CM_A_CTL2, 8'h08);
      rc(`I2CM_A_CTL1, 8'h80, 8'h80);
      wt(`I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_1, `I2CM_IRQ_BIT);
      chk(cap[8:1], d);
      rc(`I2CM_A_CTL2, 8'h48, k ? 8'h00 : 8'h40);
      rc(`I2CM_A_STAT, 8'h01, 8'h00);
      rc(`I2CM_A_CTL1, 8'h80, 8'h80);
      acc(1'b1, `I2CM_A_CTL1, 8'h20);
      acc(1'b1, `I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h00);
    end
    send <= 1'b1;
    cpu_sleep <= 1'b1;
    acc(1'b1, `I2CM_A_PERIPHERAL_INTERRUPT_ENABLES_1, 8'h08);
    for (k = 0; k < 2; k = k + 1) begin
      b[k] = 8'($urandom);
      prep(b[k]);
      acc(1'b1, `I2CM_A_CTL2, 8'h08);
      acc(1'b1, `I2CM_A_BUF, 8'hA5);
      wt(`I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_1, `I2CM_IRQ_BIT);
      chk({7'h0, wake_req}, 8'h01);
      rc(`I2CM_A_CTL2, 8'h08, 8'h00);
      rc(`I2CM_A_STAT, 8'h01, 8'h01);
      acc(1'b1, `I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h00);
      @(negedge core_clk);
      chk({7'h0, wake_req}, 8'h00);
      acc(1'b1, `I2CM_A_CTL2, 8'h10);
      wt(`I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_1, `I2CM_IRQ_BIT);
      chk({6'h0, cap[1:0]}, {6'h0, b[k][0], 1'b0});
      rc(`I2CM_A_CTL2, 8'h10, 8'h00);
      acc(1'b1, `I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h00);
    end
    rc(`I2CM_A_CTL1, 8'hC0, 8'hC0);
    rc(`I2CM_A_BUF, 8'hFF, b[0]);
    rc(`I2CM_A_STAT, 8'h01, 8'h00);
    send <= 1'b0;
    prep(8'h00);
    acc(1'b1, `I2CM_A_BUF, 8'hFF);
    collide <= 1'b1;
    wt(`I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_2, `I2CM_BCL_BIT);
    chk({6'h0, scl_oe_n, sda_oe_n}, 8'h03);
    rc(`I2CM_A_STAT, 8'h01, 8'h00);
    collide <= 1'b0;
    wt(`I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_1, `I2CM_IRQ_BIT);
    rc(`I2CM_A_STAT, 8'h10, 8'h10);
    acc(1'b1, `I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h00);
    acc(1'b1, `I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_2, 8'h00);
    acc(1'b1, `I2CM_A_CTL1, 8'h20);
    acc(1'b1, `I2CM_A_CTL2, 8'h01);
    wt(`I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_1, `I2CM_IRQ_BIT);
    rc(`I2CM_A_STAT, 8'h18, 8'h08);
    rc(`I2CM_A_CTL2, 8'h01, 8'h00);
    acc(1'b1, `I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h00);
    d = 8'($urandom);
    prep(8'h00);
    acc(1'b1, `I2CM_A_BUF, d);
    wt(`I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_1, `I2CM_IRQ_BIT);
    chk(cap[8:1], d);
    rc(`I2CM_A_CTL1, 8'h80, 8'h00);
    acc(1'b1, `I2CM_A_CTL1, 8'h00);
    rc(`I2CM_A_STAT, 8'h18, 8'h00);
    acc(1'b1, `I2CM_A_CTL1, 8'h20);
    acc(1'b1, `I2CM_A_BUF, 8'h3C);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    chk({6'h0, scl_oe_n, sda_oe_n}, 8'h03);
    rc(`I2CM_A_CTL1, 8'hFF, 8'h00);
    acc(1'b1, `I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h00);
    acc(1'b1, `I2CM_A_CTL1, 8'h20);
    collide <= 1'b1;
    rc(`I2CM_A_STAT, 8'h18, 8'h08);
    collide <= 1'b0;
    wt(`I2CM_A_PERIPHERAL_INTERRUPT_FLAGS_1, `I2CM_IRQ_BIT);
    rc(`I2CM_A_STAT, 8'h10, 8'h10);
    close_out;
  end
endmodule // test_i2c_master_flags_and_arbitration
